// ### ldisr_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldisr_cfg.svh"
module ldisr_master (
	ldisr_if.master bus,
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdRead,
	input wire logic [6:0] cmdDevAddr,
	input wire logic [7:0] cmdRegIdx,
	input wire logic [3:0] cmdLen,
	input wire logic [7:0] wrData,
	output logic wrTake,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic done,
	output logic doneErr
);
	localparam logic [11:0] QUARTER = 12'(`LDISR_QUARTER_CYCLES);

	ldisr_pkg::ldisr_mst_state_e state;
	ldisr_pkg::ldisr_stage_e stage;
	logic [11:0] qCnt;
	logic [1:0] phase;
	logic qTick;
	logic sdaMeta;
	logic sdaSync;
	logic [3:0] bitIdx;
	logic [7:0] txShift;
	logic [7:0] rxShift;
	logic ackBit;
	logic [3:0] remaining;
	logic isRead;
	logic [6:0] devAddr;
	logic [7:0] regIdx;
	logic sclOut;
	logic sdaLow;

	assign qTick = (qCnt == QUARTER - 12'h001);
	assign cmdReady = (state == ldisr_pkg::MST_IDLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
		end else begin
			sdaMeta <= bus.sda;
			sdaSync <= sdaMeta;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			qCnt <= 12'h000;
			phase <= 2'h0;
		end else if (state == ldisr_pkg::MST_IDLE) begin
			qCnt <= 12'h000;
			phase <= 2'h0;
		end else if (qTick) begin
			qCnt <= 12'h000;
			phase <= phase + 2'h1;
		end else begin
			qCnt <= qCnt + 12'h001;
		end
	end

	// line levels per quarter; SDA moves only in quarters with SCL low,
	// except for the start and stop conditions themselves
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclOut <= 1'b1;
			sdaLow <= 1'b0;
		end else begin
			unique case (state)
				ldisr_pkg::MST_IDLE: begin
					sclOut <= 1'b1;
					sdaLow <= 1'b0;
				end
				ldisr_pkg::MST_START: begin
					sclOut <= (phase == 2'h1 || phase == 2'h2);
					sdaLow <= phase[1];
				end
				ldisr_pkg::MST_BIT: begin
					sclOut <= (phase == 2'h1 || phase == 2'h2);
					if (bitIdx == `LDISR_ACK_SLOT) begin
						sdaLow <= (stage == ldisr_pkg::STG_RDATA && remaining != 4'h1);
					end else begin
						sdaLow <= (stage != ldisr_pkg::STG_RDATA) && !txShift[7];
					end
				end
				ldisr_pkg::MST_STOP: begin
					sclOut <= (phase != 2'h0);
					sdaLow <= !phase[1];
				end
			endcase
		end
	end

	assign bus.scl = sclOut;
	assign bus.mstSdaOe = sdaLow;
	assign bus.mstSdaOut = 1'b0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ldisr_pkg::MST_IDLE;
			stage <= ldisr_pkg::STG_ADDRW;
			bitIdx <= 4'h0;
			txShift <= 8'h00;
			rxShift <= 8'h00;
			ackBit <= 1'b1;
			remaining <= 4'h0;
			isRead <= 1'b0;
			devAddr <= 7'h00;
			regIdx <= 8'h00;
			wrTake <= 1'b0;
			rdData <= 8'h00;
			rdValid <= 1'b0;
			done <= 1'b0;
			doneErr <= 1'b0;
		end else begin
			wrTake <= 1'b0;
			rdValid <= 1'b0;
			done <= 1'b0;
			unique case (state)
				ldisr_pkg::MST_IDLE: begin
					if (cmdValid) begin
						state <= ldisr_pkg::MST_START;
						stage <= ldisr_pkg::STG_ADDRW;
						isRead <= cmdRead;
						devAddr <= cmdDevAddr;
						regIdx <= cmdRegIdx;
						remaining <= (cmdRead && cmdLen == 4'h0) ? 4'h1 : cmdLen;
						txShift <= {cmdDevAddr, `LDISR_DIR_WRITE};
						doneErr <= 1'b0;
					end
				end
				ldisr_pkg::MST_START: begin
					if (qTick && phase == 2'h3) begin
						state <= ldisr_pkg::MST_BIT;
						bitIdx <= 4'h0;
					end
				end
				ldisr_pkg::MST_STOP: begin
					if (qTick && phase == 2'h3) begin
						state <= ldisr_pkg::MST_IDLE;
						done <= 1'b1;
					end
				end
				ldisr_pkg::MST_BIT: begin
					if (qTick && phase == 2'h2) begin
						if (bitIdx == `LDISR_ACK_SLOT) begin
							ackBit <= sdaSync;
						end else begin
							rxShift <= {rxShift[6:0], sdaSync};
						end
					end
					if (qTick && phase == 2'h3) begin
						if (bitIdx != `LDISR_ACK_SLOT) begin
							bitIdx <= bitIdx + 4'h1;
							txShift <= {txShift[6:0], 1'b0};
						end else begin
							bitIdx <= 4'h0;
							if (stage != ldisr_pkg::STG_RDATA && ackBit) begin
								state <= ldisr_pkg::MST_STOP;
								doneErr <= 1'b1;
							end else begin
								unique case (stage)
									ldisr_pkg::STG_ADDRW: begin
										stage <= ldisr_pkg::STG_IDX;
										txShift <= regIdx;
									end
									ldisr_pkg::STG_IDX: begin
										if (isRead) begin
											state <= ldisr_pkg::MST_START;
											stage <= ldisr_pkg::STG_ADDRR;
											txShift <= {devAddr, `LDISR_DIR_READ};
										end else if (remaining == 4'h0) begin
											state <= ldisr_pkg::MST_STOP;
										end else begin
											stage <= ldisr_pkg::STG_WDATA;
											txShift <= wrData;
											wrTake <= 1'b1;
										end
									end
									ldisr_pkg::STG_WDATA: begin
										remaining <= remaining - 4'h1;
										if (remaining == 4'h1) begin
											state <= ldisr_pkg::MST_STOP;
										end else begin
											txShift <= wrData;
											wrTake <= 1'b1;
										end
									end
									ldisr_pkg::STG_ADDRR: begin
										stage <= ldisr_pkg::STG_RDATA;
									end
									ldisr_pkg::STG_RDATA: begin
										rdData <= rxShift;
										rdValid <= 1'b1;
										remaining <= remaining - 4'h1;
										if (remaining == 4'h1) begin
											state <= ldisr_pkg::MST_STOP;
										end
									end
									default: begin
										state <= ldisr_pkg::MST_STOP;
									end
								endcase
							end
						end
					end
				end
			endcase
		end
	end

endmodule : ldisr_master
`default_nettype wire

// ### ldisr_cfg.svh
`ifndef LDISR_CFG_SVH
`define LDISR_CFG_SVH

// bus address: base with the select pin in the low bit
`define LDISR_ADDR_BASE 7'h4C
`define LDISR_DIR_READ 1'b1
`define LDISR_DIR_WRITE 1'b0

// channel register indices
`define LDISR_IDX_SET1_RED 8'h00
`define LDISR_IDX_SET1_GREEN 8'h01
`define LDISR_IDX_SET1_BLUE 8'h02
`define LDISR_IDX_SET2_RED 8'h03
`define LDISR_IDX_SET2_GREEN 8'h04
`define LDISR_IDX_SET2_BLUE 8'h05
`define LDISR_IDX_SET3_RED 8'h06
`define LDISR_IDX_SET3_GREEN 8'h07
`define LDISR_IDX_SET3_BLUE 8'h08
`define LDISR_IDX_SET4_RED 8'h09
`define LDISR_IDX_SET4_GREEN 8'h0A
`define LDISR_CHAN_COUNT 11
`define LDISR_CHAN_RESET 8'h00
`define LDISR_UNMAPPED_READ 8'h00

// field positions inside a channel register
`define LDISR_PULSE_MSB 7
`define LDISR_PULSE_LSB 6
`define LDISR_DUTY_MSB 5
`define LDISR_DUTY_LSB 0

// bit counter: eight data bits then the acknowledge slot
`define LDISR_ACK_SLOT 4'h8
`define LDISR_LAST_DATA_BIT 4'h7

// master timing
`define LDISR_CLK_PERIOD_NS 8
`define LDISR_SCL_PERIOD_NS 2500
`define LDISR_QUARTER_CYCLES ((`LDISR_SCL_PERIOD_NS / `LDISR_CLK_PERIOD_NS) / 4)

`endif

// ### ldisr_pkg.sv
`default_nettype none
package ldisr_pkg;

	typedef struct packed {
		logic [1:0] pulseLevelField;
		logic [5:0] duty;
	} ldisr_chan_s;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_ADDR = 3'h1,
		DEV_REGIDX = 3'h2,
		DEV_WDATA = 3'h3,
		DEV_RDATA = 3'h4,
		DEV_IGNORE = 3'h5
	} ldisr_dev_state_e;

	typedef enum logic [1:0] {
		MST_IDLE = 2'h0,
		MST_START = 2'h1,
		MST_BIT = 2'h2,
		MST_STOP = 2'h3
	} ldisr_mst_state_e;

	typedef enum logic [2:0] {
		STG_ADDRW = 3'h0,
		STG_IDX = 3'h1,
		STG_WDATA = 3'h2,
		STG_ADDRR = 3'h3,
		STG_RDATA = 3'h4
	} ldisr_stage_e;

endpackage : ldisr_pkg
`default_nettype wire

// ### ldisr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ldisr_if;
	logic scl;
	logic mstSdaOut;
	logic mstSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic sda;

	// open-drain wire with pull-up
	assign sda = (mstSdaOe ? mstSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

	modport device(input scl, input sda, output devSdaOut, output devSdaOe);
	modport master(output scl, output mstSdaOut, output mstSdaOe, input sda);
endinterface : ldisr_if
`default_nettype wire

// ### ldisr_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldisr_cfg.svh"
module ldisr_device (
	ldisr_if.device bus,
	input wire logic resetn,
	input wire logic addressSelectPin,
	output var ldisr_pkg::ldisr_chan_s chanReg [`LDISR_CHAN_COUNT]
);
	logic startTgl;
	logic stopTgl;
	logic startSeen;
	logic stopSeen;
	logic selMeta;
	logic selSync;
	ldisr_pkg::ldisr_dev_state_e state;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] txShift;
	logic [7:0] regIdx;
	logic ackPend;
	logic rwBit;
	logic sdaLow;
	logic newStart;
	logic stopPend;
	logic [7:0] rxByte;
	logic [6:0] ownAddr;

	function automatic logic [7:0] readChannel(input logic [7:0] idx,
			input ldisr_pkg::ldisr_chan_s regs [`LDISR_CHAN_COUNT]);
		logic [7:0] val;
		val = `LDISR_UNMAPPED_READ;
		for (int i = 0; i < `LDISR_CHAN_COUNT; i++) begin
			if (idx == 8'(i)) begin
				val = regs[i];
			end
		end
		return val;
	endfunction : readChannel

	// conditions on SDA edges while SCL is high; the toggles settle while SCL
	// is still high, three quarters of a period before the next rising SCL samples them
	always_ff @(negedge bus.sda or negedge resetn) begin
		if (!resetn) begin
			startTgl <= 1'b0;
		end else if (bus.scl) begin
			startTgl <= ~startTgl;
		end
	end

	always_ff @(posedge bus.sda or negedge resetn) begin
		if (!resetn) begin
			stopTgl <= 1'b0;
		end else if (bus.scl) begin
			stopTgl <= ~stopTgl;
		end
	end

	assign newStart = startTgl ^ startSeen;
	assign stopPend = stopTgl ^ stopSeen;
	assign rxByte = {shiftIn[6:0], bus.sda};
	assign ownAddr = `LDISR_ADDR_BASE | {6'h00, selSync};

	always_ff @(posedge bus.scl or negedge resetn) begin
		if (!resetn) begin
			startSeen <= 1'b0;
			stopSeen <= 1'b0;
			selMeta <= 1'b0;
			selSync <= 1'b0;
		end else begin
			startSeen <= startTgl;
			stopSeen <= stopTgl;
			selMeta <= addressSelectPin;
			selSync <= selMeta;
		end
	end

	always_ff @(posedge bus.scl or negedge resetn) begin
		if (!resetn) begin
			state <= ldisr_pkg::DEV_IDLE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			txShift <= 8'h00;
			regIdx <= 8'h00;
			ackPend <= 1'b0;
			rwBit <= 1'b0;
		end else if (newStart) begin
			// this rising edge carries the first address bit
			state <= ldisr_pkg::DEV_ADDR;
			shiftIn <= {7'h00, bus.sda};
			bitCnt <= 4'h1;
			ackPend <= 1'b0;
		end else if (stopPend) begin
			state <= ldisr_pkg::DEV_IDLE;
			bitCnt <= 4'h0;
			ackPend <= 1'b0;
		end else if (state != ldisr_pkg::DEV_IDLE && state != ldisr_pkg::DEV_IGNORE) begin
			if (bitCnt != `LDISR_ACK_SLOT) begin
				shiftIn <= rxByte;
				txShift <= {txShift[6:0], 1'b0};
				bitCnt <= bitCnt + 4'h1;
				if (bitCnt == `LDISR_LAST_DATA_BIT) begin
					unique case (state)
						ldisr_pkg::DEV_ADDR: begin
							ackPend <= (rxByte[7:1] == ownAddr);
							rwBit <= rxByte[0];
						end
						ldisr_pkg::DEV_REGIDX: begin
							regIdx <= rxByte;
							ackPend <= 1'b1;
						end
						ldisr_pkg::DEV_WDATA: begin
							ackPend <= 1'b1;
						end
						ldisr_pkg::DEV_RDATA: begin
							ackPend <= 1'b0;
						end
					endcase
				end
			end else begin
				bitCnt <= 4'h0;
				unique case (state)
					ldisr_pkg::DEV_ADDR: begin
						if (!ackPend) begin
							state <= ldisr_pkg::DEV_IGNORE;
						end else if (rwBit == `LDISR_DIR_READ) begin
							state <= ldisr_pkg::DEV_RDATA;
							txShift <= readChannel(regIdx, chanReg);
						end else begin
							state <= ldisr_pkg::DEV_REGIDX;
						end
					end
					ldisr_pkg::DEV_REGIDX: begin
						state <= ldisr_pkg::DEV_WDATA;
					end
					ldisr_pkg::DEV_WDATA: begin
						regIdx <= regIdx + 8'h01;
					end
					ldisr_pkg::DEV_RDATA: begin
						if (!bus.sda) begin
							regIdx <= regIdx + 8'h01;
							txShift <= readChannel(regIdx + 8'h01, chanReg);
						end else begin
							state <= ldisr_pkg::DEV_IGNORE;
						end
					end
				endcase
			end
		end
	end

	// channel registers take the byte on its eighth rising edge
	always_ff @(posedge bus.scl or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `LDISR_CHAN_COUNT; i++) begin
				chanReg[i] <= `LDISR_CHAN_RESET;
			end
		end else if (!newStart && !stopPend && state == ldisr_pkg::DEV_WDATA &&
				bitCnt == `LDISR_LAST_DATA_BIT) begin
			for (int i = 0; i < `LDISR_CHAN_COUNT; i++) begin
				if (regIdx == 8'(i)) begin
					chanReg[i] <= rxByte;
				end
			end
		end
	end

	// SDA changes only while SCL is low
	always_ff @(negedge bus.scl or negedge resetn) begin
		if (!resetn) begin
			sdaLow <= 1'b0;
		end else begin
			sdaLow <= (bitCnt == `LDISR_ACK_SLOT && ackPend &&
				(state == ldisr_pkg::DEV_ADDR || state == ldisr_pkg::DEV_REGIDX ||
				state == ldisr_pkg::DEV_WDATA)) ||
				(state == ldisr_pkg::DEV_RDATA && bitCnt != `LDISR_ACK_SLOT &&
				!txShift[7]);
		end
	end

	// a pending condition drops the drive at once, since SCL may not toggle again
	assign bus.devSdaOe = sdaLow && !newStart && !stopPend;
	assign bus.devSdaOut = 1'b0;

endmodule : ldisr_device
`default_nettype wire

// ### ldisr_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldisr_cfg.svh"
module ldisr_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic mstSdaOe,
	input wire logic devSdaOe
);
	localparam int HIGH_MIN = 2 * `LDISR_QUARTER_CYCLES - 1;
	logic sclQ;
	logic sdaQ;
	logic dirRead;
	logic [7:0] riseCnt;
	logic [15:0] highCnt;
	logic [7:0] bitNo;
	logic ackSlot;
	// count includes a rise seen in this very sample, so slots line up with the wire
	assign bitNo = riseCnt + {7'h00, scl && !sclQ};
	assign ackSlot = (bitNo % 9 == 8 && !scl) || (bitNo % 9 == 0 && scl);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			riseCnt <= 8'h00;
		else if (scl && sclQ && sdaQ && !sda)
			riseCnt <= 8'h00;
		else if (scl && !sclQ && riseCnt != 8'hFF)
			riseCnt <= riseCnt + 8'h01;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			dirRead <= 1'b0;
		else if (scl && !sclQ && riseCnt == 8'h07)
			dirRead <= sda;
	end
	always_ff @(posedge clk or negedge resetn) begin
		// an idle bus counts as long high, so the first fall after reset is legal
		if (!resetn)
			highCnt <= 16'hFFFF;
		else if (!scl)
			highCnt <= 16'h0000;
		else if (highCnt != 16'hFFFF)
			highCnt <= highCnt + 16'h0001;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence startSeq;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stopSeq;
		scl && $past(scl) && $rose(sda);
	endsequence
	AST_DEV_STABLE_HIGH: assert property (scl && sclQ |-> $stable(devSdaOe))
		else $error("device moved SDA while SCL high");
	// both ends may pull together for a moment at the SCL fall that hands over SDA
	AST_NO_CLASH: assert property (!(scl && mstSdaOe && devSdaOe))
		else $error("both ends pull SDA while SCL high");
	AST_HANDOVER_SHORT: assert property (
		mstSdaOe && devSdaOe |-> ##[1:100] !(mstSdaOe && devSdaOe))
		else $error("SDA hand-over lasted too long");
	AST_ADDR_QUIET: assert property (devSdaOe |-> bitNo >= 8'h08)
		else $error("device drove SDA during address");
	AST_STOP_RELEASE: assert property (stopSeq |=> !devSdaOe [*8])
		else $error("device drove SDA after stop");
	AST_WRITE_ACK_SLOT: assert property (
		!dirRead && bitNo >= 8'h08 && devSdaOe |-> ackSlot)
		else $error("device drove SDA outside ack slot in write");
	AST_READ_MASTER_SLOT: assert property (
		dirRead && bitNo >= 8'h11 && ackSlot |-> !devSdaOe)
		else $error("device held SDA in master ack slot");
	AST_DEV_EDGE: assert property ($rose(devSdaOe) |-> $fell(scl))
		else $error("device pull not on SCL fall");
	AST_SCL_HIGH_TIME: assert property ($fell(scl) |-> highCnt >= HIGH_MIN)
		else $error("SCL high phase too short");
	AST_START_THEN_LOW: assert property (startSeq |-> ##[1:200] !scl)
		else $error("SCL not lowered after start");
endmodule : ldisr_checker
`default_nettype wire

// ### led_driver_i2c_slave_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldisr_cfg.svh"
module led_driver_i2c_slave_regs_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic addressSelectPin = 1'b0;
	logic cmdValid = 1'b0;
	logic cmdRead = 1'b0;
	logic [6:0] cmdDevAddr = 7'h00;
	logic [7:0] cmdRegIdx = 8'h00;
	logic [3:0] cmdLen = 4'h0;
	logic [7:0] wrData;
	logic cmdReady;
	logic wrTake;
	logic rdValid;
	logic done;
	logic doneErr;
	logic [7:0] rdData;
	ldisr_pkg::ldisr_chan_s chanReg [`LDISR_CHAN_COUNT];
	logic [7:0] wBuf [4] = '{8'hC3, 8'h3C, 8'h7E, 8'h81};
	logic [7:0] rBuf [4];
	logic [1:0] wIdx = 2'h0;
	int rIdx = 0;
	int miscompares = 0;
	int tests_run = 0;
	ldisr_if bus ();
	always #4 clk = ~clk;
	assign wrData = wBuf[wIdx];
	// the master loads wrData on the edge that raises wrTake, so advance only after the next edge
	always @(posedge clk) begin
		if (wrTake === 1'b1)
			wIdx <= #1 wIdx + 2'h1;
		if (rdValid === 1'b1) begin
			rBuf[rIdx[1:0]] <= rdData;
			rIdx <= rIdx + 1;
		end
	end
	ldisr_master ldisr_master_i (.bus(bus), .clk(clk), .resetn(resetn), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdRead(cmdRead), .cmdDevAddr(cmdDevAddr), .cmdRegIdx(cmdRegIdx),
		.cmdLen(cmdLen), .wrData(wrData), .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid),
		.done(done), .doneErr(doneErr));
	ldisr_device ldisr_device_i (.bus(bus), .resetn(resetn),
		.addressSelectPin(addressSelectPin), .chanReg(chanReg));
	ldisr_checker ldisr_checker_i (.clk(clk), .resetn(resetn), .scl(bus.scl), .sda(bus.sda),
		.mstSdaOe(bus.mstSdaOe), .devSdaOe(bus.devSdaOe));
	task stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	// called just after a rising edge; returns just after the edge that follows done
	task xfer(input logic rd, input logic [6:0] a, input logic [7:0] idx, input logic [3:0] len);
		int n;
		n = 0;
		wIdx = 2'h0;
		rIdx = 0;
		cmdRead = rd;
		cmdDevAddr = a;
		cmdRegIdx = idx;
		cmdLen = len;
		cmdValid = 1'b1;
		@(posedge clk);
		#1 cmdValid = 1'b0;
		while (done !== 1'b1 && n < 40000) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 40000)
			miscompares++;
		@(posedge clk);
		#1;
	endtask : xfer
	initial begin
		#600000;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 resetn = 1'b1;
		for (int i = 0; i < `LDISR_CHAN_COUNT; i++)
			check(chanReg[i], `LDISR_CHAN_RESET);
		// burst runs past the last channel; the third byte must vanish
		xfer(`LDISR_DIR_WRITE, `LDISR_ADDR_BASE, `LDISR_IDX_SET4_RED, 4'h3);
		check({7'h00, doneErr}, 8'h00);
		check(chanReg[9], 8'hC3);
		check(chanReg[10], 8'h3C);
		check(chanReg[8], 8'h00);
		check({7'h00, cmdReady}, 8'h01);
		check({6'h00, chanReg[9].pulseLevelField}, 8'h03);
		check({2'h0, chanReg[10].duty}, 8'h3C);
		xfer(`LDISR_DIR_READ, `LDISR_ADDR_BASE, `LDISR_IDX_SET4_RED, 4'h3);
		check({7'h00, doneErr}, 8'h00);
		check(8'(rIdx), 8'h03);
		check(rBuf[0], 8'hC3);
		check(rBuf[1], 8'h3C);
		check(rBuf[2], `LDISR_UNMAPPED_READ);
		addressSelectPin = 1'b1;
		xfer(`LDISR_DIR_WRITE, `LDISR_ADDR_BASE, `LDISR_IDX_SET1_RED, 4'h1);
		check({7'h00, doneErr}, 8'h01);
		check(chanReg[0], 8'h00);
		xfer(`LDISR_DIR_WRITE, `LDISR_ADDR_BASE | 7'h01, `LDISR_IDX_SET1_RED, 4'h1);
		check({7'h00, doneErr}, 8'h00);
		check(chanReg[0], 8'hC3);
		addressSelectPin = 1'b0;
		xfer(`LDISR_DIR_WRITE, `LDISR_ADDR_BASE | 7'h01, `LDISR_IDX_SET1_GREEN, 4'h1);
		check({7'h00, doneErr}, 8'h01);
		check(chanReg[1], 8'h00);
		// a reset in mid-run must clear a channel that was written
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		check(chanReg[0], `LDISR_CHAN_RESET);
		stop_test();
	end
endmodule : led_driver_i2c_slave_regs_bench
`default_nettype wire
